// ---- verilog/spi_pkg.sv ----
// Purpose: Shared constants for the single-pin program interface
// Assumes: 250 MHz system clock
// Notes:   Times kept in their own unit, cycle counts derived from them
package spi_pkg;
  localparam int CLK_MHZ        = 250;
  localparam int TIMEOUT_MS     = 16;
  localparam int TIMEOUT_CYC    = TIMEOUT_MS * CLK_MHZ * 1000;
  // Nominal bit period at 70 kHz is about 14.3 us; sample at half of it
  localparam int SAMPLE_NS      = 7140;
  localparam int SAMPLE_CYC     = (SAMPLE_NS * CLK_MHZ) / 1000;
  localparam int CMD_LEN        = 6;
  localparam int INSTR_LEN      = 11;
  localparam int SEL_W          = 3;
  localparam int WORD_W         = 8;
  localparam int NUM_WORDS      = 6;
  localparam int RB_BITS        = 59;
  localparam logic [5:0]  CODE_PROG     = 6'h0C;
  localparam logic [5:0]  CODE_READBACK = 6'h3B;
  localparam logic [2:0]  SEL_JUMP      = 3'h7;
  localparam logic [7:0]  JMP_NOLOCK    = 8'hF0;
  localparam logic [7:0]  JMP_LOCK      = 8'h55;
  localparam logic [7:0]  JMP_EXIT      = 8'h00;
  localparam logic [7:0]  WORD_RESET    = 8'h00;
  localparam int          SEL_LVDS_BIT  = 0;
  localparam logic [2:0]  REVISION      = 3'h1; // Arbitrary value
  localparam logic [5:0]  VCO_CAL       = 6'h00;
  typedef enum logic [2:0] {
    ST_NORMAL, ST_PROG, ST_EE_NOLOCK, ST_EE_LOCK, ST_READBACK
  } spi_state_t;
endpackage : spi_pkg

// ---- verilog/spi_bit_decoder.sv ----
// Purpose: Turns high pulses on the program pin into bits
// Assumes: Pin already synchronous to CLK_I
// Notes:   Delayed copy of the rising edge strobes the live level
`timescale 1ns/1ps
module spi_bit_decoder #(
  parameter int SAMPLE_CYCLES  = 1785,
  parameter int TIMEOUT_CYCLES = 4000000
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      bit_valid_o,
  output logic      bit_value_o,
  output logic      rise_o,
  output logic      timeout_o
);
  logic        pin_ff;
  logic [11:0] dly_cnt_ff;
  logic        delayed_program_signal_ff;
  logic [22:0] idle_cnt_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) pin_ff <= 1'b0;
    else       pin_ff <= pin_i;
  end

  assign rise_o = pin_i & ~pin_ff;

  // Counter from the rising edge forms the delayed strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dly_cnt_ff                <= 12'h000;
      delayed_program_signal_ff <= 1'b0;
    end else begin
      delayed_program_signal_ff <= 1'b0;
      if (rise_o) dly_cnt_ff <= 12'h001;
      else if (dly_cnt_ff != 12'h000) begin
        if (dly_cnt_ff == 12'(SAMPLE_CYCLES)) begin
          dly_cnt_ff                <= 12'h000;
          delayed_program_signal_ff <= 1'b1;
        end else dly_cnt_ff <= dly_cnt_ff + 12'h001;
      end
    end
  end

  // Still high at the strobe is a long pulse, a one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bit_valid_o <= 1'b0;
      bit_value_o <= 1'b0;
    end else begin
      bit_valid_o <= delayed_program_signal_ff;
      bit_value_o <= pin_i;
    end
  end

  // Either level held too long flags a time-out, which clears only in normal state; gaps shorter leave data alone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_cnt_ff <= 23'h000000;
      timeout_o   <= 1'b0;
    end else begin
      timeout_o <= 1'b0;
      if (pin_i != pin_ff) idle_cnt_ff <= 23'h000000;
      else if (idle_cnt_ff == 23'(TIMEOUT_CYCLES)) begin
        idle_cnt_ff <= 23'h000000;
        timeout_o   <= 1'b1;
      end else idle_cnt_ff <= idle_cnt_ff + 23'h000001;
    end
  end
endmodule : spi_bit_decoder

// ---- verilog/spi_output_gate.sv ----
// Purpose: Picks one output driver and applies chip enable
// Assumes: Readback bits alone drive the clock output pin; CLK_DATA_I is not used
// Notes:   Enables are registered so outputs come from flip-flops
`timescale 1ns/1ps
module spi_output_gate (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic sel_lvds_i,
  input  wire logic ce_i,
  input  wire logic ce_ignore_i,
  output logic      lvds_en_o,
  output logic      lvpecl_en_o
);
  logic on;
  assign on = ce_i | ce_ignore_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvds_en_o   <= 1'b0;
      lvpecl_en_o <= 1'b0;
    end else begin
      lvds_en_o   <= on & sel_lvds_i;
      lvpecl_en_o <= on & ~sel_lvds_i;
    end
  end
endmodule : spi_output_gate

// ---- verilog/spi_program_if.sv ----
// Purpose: Single-pin program interface: command decode, word store, readback
// Assumes: Program pin synchronous to CLK_I; one clock domain
// Notes:   Nonvolatile array modelled as a flop shadow with a write strobe
`timescale 1ns/1ps
module spi_program_if
  import spi_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = spi_pkg::TIMEOUT_CYC,
  parameter int SAMPLE_CYCLES  = spi_pkg::SAMPLE_CYC
) (
  // Clock and reset
  input  wire logic       CLK_I,
  input  wire logic       RST_I,
  // Pins
  input  wire logic       PROGRAM_PIN_I,
  input  wire logic       CE_I,
  input  wire logic       CLK_DATA_I,
  // Output driver control
  output logic            LVDS_EN_O,
  output logic            LVPECL_EN_O,
  output logic            CLOCK_OUTPUT_PIN_O,
  output logic            READBACK_ACTIVE_O,
  // Configuration and nonvolatile status
  output logic [47:0]     CONFIG_O,
  output logic            EE_WRITE_O,
  output logic            EE_LOCKED_O,
  output logic [2:0]      STATE_O
);
  import spi_pkg::*;

  spi_state_t  state_ff, nxt_state;
  logic [10:0] shift_ff;
  logic [3:0]  cnt_ff;
  logic [7:0]  word_ff [NUM_WORDS];
  logic [7:0]  ee_ff   [NUM_WORDS];
  logic        ee_written_ff;
  logic [58:0] rb_ff;
  logic [5:0]  rb_cnt_ff;
  logic        bit_valid, bit_value, rise, timeout;
  logic [10:0] nxt_shift;
  logic        instr_done, cmd_done, clear;
  logic [7:0]  payload;

  spi_bit_decoder #(
    .SAMPLE_CYCLES  (SAMPLE_CYCLES),
    .TIMEOUT_CYCLES (TIMEOUT_CYCLES)
  ) u_dec (
    .clk_i       (CLK_I),
    .rst_i       (RST_I),
    .pin_i       (PROGRAM_PIN_I),
    .bit_valid_o (bit_valid),
    .bit_value_o (bit_value),
    .rise_o      (rise),
    .timeout_o   (timeout)
  );

  // Selector read first-bit-first: 000 word0, 100 word1 ... 101 word5
  function automatic logic [2:0] sel_index(input logic [2:0] s);
    sel_index = {s[0], s[1], s[2]};
  endfunction : sel_index

  // Stored words leave the readback chain most significant bit first
  function automatic logic [7:0] msb_first(input logic [7:0] w);
    for (int b = 0; b < WORD_W; b++) msb_first[b] = w[WORD_W-1-b];
  endfunction : msb_first

  // Selector keeps its first-sent bit in the high position
  assign nxt_shift  = {shift_ff[9:0], bit_value};
  assign cmd_done   = bit_valid && (cnt_ff == 4'(CMD_LEN - 1));
  assign instr_done = bit_valid && (cnt_ff == 4'(INSTR_LEN - 1));
  assign payload    = nxt_shift[WORD_W-1:0];

  always_comb begin
    nxt_state = state_ff;
    clear     = 1'b0;
    unique case (state_ff)
      ST_NORMAL: begin
        if (timeout) clear = 1'b1;
        else if (cmd_done) begin
          clear = 1'b1;
          if (nxt_shift[5:0] == CODE_PROG) nxt_state = ST_PROG;
          else if (nxt_shift[5:0] == CODE_READBACK) nxt_state = ST_READBACK;
        end
      end
      ST_PROG: begin
        if (instr_done) begin
          clear = 1'b1;
          if (nxt_shift[10:8] == SEL_JUMP) begin
            if (payload == JMP_NOLOCK) nxt_state = ST_EE_NOLOCK;
            else if (payload == JMP_LOCK) nxt_state = ST_EE_LOCK;
            else nxt_state = ST_NORMAL;
          end
        end
      end
      ST_EE_NOLOCK, ST_EE_LOCK: begin
        if (instr_done) begin
          clear     = 1'b1;
          nxt_state = ST_NORMAL;
        end
      end
      ST_READBACK: begin
        if (rise && rb_cnt_ff == 6'(RB_BITS + 1)) nxt_state = ST_NORMAL;
      end
      // Unused codes fall back to normal operation
      default: begin
        clear     = 1'b1;
        nxt_state = ST_NORMAL;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) state_ff <= ST_NORMAL;
    else       state_ff <= nxt_state;
  end

  // Bit collection; readback reuses the pin as a clock so shifting stops
  always_ff @(posedge CLK_I) begin
    if (RST_I || clear || state_ff == ST_READBACK) begin
      shift_ff <= 11'h000;
      cnt_ff   <= 4'h0;
    end else if (bit_valid) begin
      shift_ff <= nxt_shift;
      cnt_ff   <= cnt_ff + 4'h1;
    end
  end

  // Working storage, effective on the eleventh and last bit of the instruction
  genvar gi;
  generate
    for (gi = 0; gi < NUM_WORDS; gi++) begin : g_word
      always_ff @(posedge CLK_I) begin
        if (RST_I) word_ff[gi] <= WORD_RESET;
        else if (state_ff == ST_PROG && instr_done && nxt_shift[10:8] != SEL_JUMP
                 && sel_index(nxt_shift[10:8]) == 3'(gi))
          word_ff[gi] <= payload;
      end
      always_ff @(posedge CLK_I) begin
        if (RST_I) ee_ff[gi] <= WORD_RESET;
        else if (EE_WRITE_O) ee_ff[gi] <= word_ff[gi];
      end
      assign CONFIG_O[gi*WORD_W +: WORD_W] = word_ff[gi];
    end
  endgenerate

  // One write strobe on entry to an EEPROM state, refused once locked
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      EE_WRITE_O    <= 1'b0;
      EE_LOCKED_O   <= 1'b0;
      ee_written_ff <= 1'b0;
    end else begin
      EE_WRITE_O <= 1'b0;
      if (state_ff == ST_PROG && !EE_LOCKED_O &&
          (nxt_state == ST_EE_NOLOCK || nxt_state == ST_EE_LOCK)) begin
        EE_WRITE_O    <= 1'b1;
        ee_written_ff <= 1'b1;
        if (nxt_state == ST_EE_LOCK) EE_LOCKED_O <= 1'b1;
      end
    end
  end

  // Readback chain: first edge loads, later edges shift bit 0 out first
  always_ff @(posedge CLK_I) begin
    if (RST_I || state_ff != ST_READBACK) begin
      rb_ff              <= 59'h0;
      rb_cnt_ff          <= 6'h00;
      CLOCK_OUTPUT_PIN_O <= 1'b0;
    end else if (rise) begin
      rb_cnt_ff <= rb_cnt_ff + 6'h01;
      if (rb_cnt_ff == 6'h00) begin
        rb_ff <= {msb_first(ee_ff[0]), msb_first(ee_ff[1]), msb_first(ee_ff[2]),
                  msb_first(ee_ff[3]), msb_first(ee_ff[4]), msb_first(ee_ff[5]),
                  EE_LOCKED_O, ee_written_ff,
                  VCO_CAL[0], VCO_CAL[1], VCO_CAL[2], VCO_CAL[3], VCO_CAL[4], VCO_CAL[5],
                  REVISION[0], REVISION[1], REVISION[2]};
      end else begin
        CLOCK_OUTPUT_PIN_O <= rb_ff[0];
        rb_ff              <= {1'b0, rb_ff[58:1]};
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      READBACK_ACTIVE_O <= 1'b0;
      STATE_O           <= 3'h0;
    end else begin
      READBACK_ACTIVE_O <= (nxt_state == ST_READBACK);
      STATE_O           <= nxt_state;
    end
  end

  spi_output_gate u_gate (
    .clk_i       (CLK_I),
    .rst_i       (RST_I),
    .sel_lvds_i  (word_ff[0][SEL_LVDS_BIT]),
    .ce_i        (CE_I),
    .ce_ignore_i (state_ff != ST_NORMAL),
    .lvds_en_o   (LVDS_EN_O),
    .lvpecl_en_o (LVPECL_EN_O)
  );
endmodule : spi_program_if

// ---- bench/spi_program_if_properties.sv ----
// Purpose: Port-level properties of the single-pin program interface
// Assumes: One clock domain, synchronous active-high reset
// Notes:   State codes follow the design package
`timescale 1ns/1ps
module spi_program_if_properties
  import spi_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = 200,
  parameter int SAMPLE_CYCLES  = 20
) (
  // Clock and reset
  input wire logic        CLK_I,
  input wire logic        RST_I,
  // Watched ports
  input wire logic        PROGRAM_PIN_I,
  input wire logic        CE_I,
  input wire logic        LVDS_EN_O,
  input wire logic        LVPECL_EN_O,
  input wire logic        READBACK_ACTIVE_O,
  input wire logic [47:0] CONFIG_O,
  input wire logic        EE_WRITE_O,
  input wire logic        EE_LOCKED_O,
  input wire logic [2:0]  STATE_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  one_driver_a:
    assert property (!(LVDS_EN_O && LVPECL_EN_O)) else $error("Both drivers on");
  ce_off_a:
    assert property ((STATE_O == 3'h0 && !CE_I)[*3] |-> !LVDS_EN_O && !LVPECL_EN_O)
    else $error("Driver on with chip enable low");
  ce_ignore_a:
    assert property ((STATE_O != 3'h0 && $past(STATE_O) != 3'h0 && $fell(CE_I))
      |=> $stable({LVDS_EN_O, LVPECL_EN_O})[*3]) else $error("Chip enable not ignored");
  ee_pulse_a:
    assert property (EE_WRITE_O |=> !EE_WRITE_O) else $error("Write strobe too long");
  ee_cause_a:
    assert property ($rose(EE_WRITE_O) |-> ##[0:2] (STATE_O inside {3'h2, 3'h3}))
    else $error("Write strobe outside write states");
  lock_set_a:
    assert property ($rose(STATE_O == 3'h3) |-> ##[0:2] EE_LOCKED_O) else $error("No lock");
  lock_keep_a:
    assert property ($past(EE_LOCKED_O) |-> EE_LOCKED_O) else $error("Lock dropped");
  ee_exit_a:
    assert property (($past(STATE_O) inside {3'h2, 3'h3} && STATE_O != $past(STATE_O))
      |-> STATE_O == 3'h0) else $error("Bad exit from write state");
  cfg_source_a:
    assert property ($changed(CONFIG_O) |-> $past(STATE_O) == 3'h1)
    else $error("Config changed outside programming");
  rb_flag_a:
    assert property ($rose(STATE_O == 3'h4) |-> ##[0:1] READBACK_ACTIVE_O)
    else $error("Readback flag missing");
  bit_wait_a:
    assert property (($rose(PROGRAM_PIN_I) && STATE_O != 3'h4) |=> $stable(STATE_O)[*8])
    else $error("Bit taken too early");
endmodule : spi_program_if_properties

bind spi_program_if spi_program_if_properties #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES), .SAMPLE_CYCLES(SAMPLE_CYCLES)
) u_props (.CLK_I(CLK_I), .RST_I(RST_I), .PROGRAM_PIN_I(PROGRAM_PIN_I), .CE_I(CE_I),
  .LVDS_EN_O(LVDS_EN_O), .LVPECL_EN_O(LVPECL_EN_O), .READBACK_ACTIVE_O(READBACK_ACTIVE_O),
  .CONFIG_O(CONFIG_O), .EE_WRITE_O(EE_WRITE_O), .EE_LOCKED_O(EE_LOCKED_O), .STATE_O(STATE_O));

// ---- bench/spi_programmer_model.sv ----
// Purpose: Programmer model driving the single program pin
// Assumes: Pin sampled by the device on the same clock
// Notes:   Bit period 39 cycles; high 7 cycles is 0, high 31 is 1
`timescale 1ns/1ps
module spi_programmer_model (
  // Clock
  input  wire logic clk_i,
  // Pin
  output logic      pin_o
);
  initial pin_o = 1'b0;
  // Gap adds idle low between bits, kept below the time-out
  task automatic send(input logic [10:0] v, input int n, input int gap);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk_i) pin_o <= 1'b1;
      repeat (v[i] ? 31 : 7) @(posedge clk_i);
      pin_o <= 1'b0;
      repeat ((v[i] ? 7 : 31) + gap) @(posedge clk_i);
    end
  endtask : send
endmodule : spi_programmer_model

// ---- bench/spi_program_if_test.sv ----
// Purpose: Self-checking bench for the single-pin program interface
// Assumes: Time-out shortened to 200 cycles, sampling point to 20
// Notes:   Nonvolatile write wait scaled down to 60 cycles
`timescale 1ns/1ps
module spi_program_if_test;
  import spi_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ce_i  = 1'b1;
  logic        pin, lvds_en, lvpecl_en, rb_bit, rb_act, ee_write, ee_locked;
  logic [47:0] config_w;
  logic [2:0]  state;
  logic [7:0]  words [6] = '{8'hA5, 8'h3C, 8'h81, 8'h7E, 8'h12, 8'hC9};
  int          fails = 0;
  int          samples_checked = 0;
  int          ee_pulses = 0;

  spi_programmer_model u_prog (.clk_i(clk_i), .pin_o(pin));
  spi_program_if #(.TIMEOUT_CYCLES(200), .SAMPLE_CYCLES(20)) u_dut (
    .CLK_I(clk_i), .RST_I(rst_i), .PROGRAM_PIN_I(pin), .CE_I(ce_i), .CLK_DATA_I(1'b0),
    .LVDS_EN_O(lvds_en), .LVPECL_EN_O(lvpecl_en), .CLOCK_OUTPUT_PIN_O(rb_bit),
    .READBACK_ACTIVE_O(rb_act), .CONFIG_O(config_w), .EE_WRITE_O(ee_write),
    .EE_LOCKED_O(ee_locked), .STATE_O(state));

  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) if (ee_write === 1'b1) ee_pulses++;

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic jump(input logic [7:0] code);
    u_prog.send({3'b111, code}, 11, 0);
  endtask : jump

  task automatic t_write_words;
    logic [2:0] s;
    u_prog.send(11'(CODE_PROG), 6, 0);
    check("state", 8'(state), 8'h1);
    for (int w = 0; w < 6; w++) begin
      s = 3'(w);
      u_prog.send({s[0], s[1], s[2], words[w]}, 11, (w == 2) ? 100 : 0);
      check("config word", config_w[8*w +: 8], words[w]);
    end
    $display("Test write_words done");
  endtask : t_write_words

  task automatic t_ee;
    jump(JMP_NOLOCK);
    check("state", 8'(state), 8'h2);
    ce_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    check("lvds enable", 8'(lvds_en), 8'h1);
    ce_i <= 1'b1;
    repeat (60) @(posedge clk_i);
    jump(JMP_EXIT);
    check("state", 8'(state), 8'h0);
    u_prog.send(11'(CODE_PROG), 6, 0);
    jump(JMP_LOCK);
    check("state", 8'(state), 8'h3);
    check("lock flag", 8'(ee_locked), 8'h1);
    repeat (60) @(posedge clk_i);
    jump(JMP_EXIT);
    check("state", 8'(state), 8'h0);
    check("write strobes", 8'(ee_pulses), 8'h2);
    $display("Test ee done");
  endtask : t_ee

  task automatic t_gating;
    check("drivers", 8'({lvds_en, lvpecl_en}), 8'h2);
    ce_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    check("drivers ce low", 8'({lvds_en, lvpecl_en}), 8'h0);
    ce_i <= 1'b1;
    u_prog.send(11'(CODE_PROG), 6, 0);
    u_prog.send({3'b000, 8'hA4}, 11, 0);
    jump(8'hAA);
    check("state", 8'(state), 8'h0);
    check("drivers", 8'({lvds_en, lvpecl_en}), 8'h1);
    $display("Test gating done");
  endtask : t_gating

  task automatic t_timeout;
    u_prog.send(11'h1, 3, 0);
    repeat (250) @(posedge clk_i);
    u_prog.send(11'h4, 3, 0);
    check("state", 8'(state), 8'h0);
    repeat (250) @(posedge clk_i);
    u_prog.send(11'(CODE_PROG), 6, 0);
    check("state", 8'(state), 8'h1);
    jump(8'hAA);
    $display("Test timeout done");
  endtask : t_timeout

  task automatic t_readback;
    logic [58:0] exp;
    exp = {REVISION, VCO_CAL, 2'b11, words[5], words[4], words[3], words[2], words[1],
           words[0]};
    u_prog.send(11'(CODE_READBACK), 6, 0);
    check("state", 8'({rb_act, state}), 8'h0C);
    for (int k = 1; k <= 61; k++) begin
      u_prog.send(11'h1, 1, 0);
      if (k >= 2 && k <= 60) check("readback bit", 8'(rb_bit), 8'(exp[60-k]));
    end
    check("state", 8'(state), 8'h0);
    $display("Test readback done");
  endtask : t_readback

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_write_words();
    t_ee();
    t_gating();
    t_timeout();
    t_readback();
    summarize();
  end

  initial begin
    repeat (40000) @(posedge clk_i);
    fails++;
    $display("ERROR watchdog expected done seen hang");
    summarize();
  end
endmodule : spi_program_if_test
